// ==== rtl/erb_params.svh ====
// offsets, field positions, reset values and sizes of the embedded ram block
`ifndef ERB_PARAMS_SVH
`define ERB_PARAMS_SVH
`define ERB_AW 16
`define ERB_DW 144
`define ERB_BW 16
`define ERB_SMALL_BITS 576
`define ERB_MID_BITS 4608
`define ERB_LARGE_BITS 589824
`define ERB_SMALL_MAXW 18
`define ERB_MID_MAXW 36
`define ERB_LARGE_MINW 8
`define ERB_MIN_W 1
`define ERB_TDP_MAXW 72
`define ERB_BE_MINW 16
`define ERB_GRAN 9
`define ERB_CTRL_OFS 12'h000
`define ERB_STAT_OFS 12'h004
`define ERB_LDADR_OFS 12'h008
`define ERB_LDDAT_OFS 12'h00c
`define ERB_CTRL_MODE_LSB 0
`define ERB_CTRL_WA_LSB 4
`define ERB_CTRL_WB_LSB 8
`define ERB_CTRL_OREGA_BIT 12
`define ERB_CTRL_OREGB_BIT 13
`define ERB_CTRL_RST 32'h0000_0660
`define ERB_STAT_ERR_BIT 0
`define ERB_STAT_COLL_BIT 1
`define ERB_STAT_VAR_LSB 4
`endif

// ==== rtl/erb_pkg.sv ====
// types shared by the embedded ram block files
`include "erb_params.svh"
package erb_pkg;
	typedef enum logic [1:0] {
		ERB_SMALL = 2'h0,
		ERB_MID = 2'h1,
		ERB_LARGE = 2'h2
	} erb_variant_t;

	typedef enum logic [2:0] {
		ERB_SP = 3'h0,
		ERB_SDP = 3'h1,
		ERB_TDP = 3'h2,
		ERB_SHIFT = 3'h3,
		ERB_ROM = 3'h4,
		ERB_PACK = 3'h5
	} erb_mode_t;

	typedef struct packed {
		logic [`ERB_AW-1:0] addr;
		logic [`ERB_DW-1:0] wdata;
		logic [`ERB_BW-1:0] byteena;
		logic wren;
		logic rden;
		logic addr_stall;
	} erb_req_t;

	// width code to port width, zero for an unused code
	function automatic logic [7:0] erb_width(input logic [3:0] c);
		case (c)
			4'h0: erb_width = 8'd1;
			4'h1: erb_width = 8'd2;
			4'h2: erb_width = 8'd4;
			4'h3: erb_width = 8'd8;
			4'h4: erb_width = 8'd9;
			4'h5: erb_width = 8'd16;
			4'h6: erb_width = 8'd18;
			4'h7: erb_width = 8'd32;
			4'h8: erb_width = 8'd36;
			4'h9: erb_width = 8'd64;
			4'ha: erb_width = 8'd72;
			4'hb: erb_width = 8'd128;
			4'hc: erb_width = 8'd144;
			default: erb_width = 8'd0;
		endcase
	endfunction
endpackage

// ==== rtl/erb_port.sv ====
// one user port: input stage, array read stage and optional output stage
`timescale 1ns/10ps
`default_nettype none
`include "erb_params.svh"
module erb_port import erb_pkg::*; #(
	parameter bit ACE = 1'b1
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clr_in,
	input wire logic clr_out,
	input wire logic out_reg_en,
	input wire erb_req_t req,
	input wire logic [`ERB_DW-1:0] rd_word,
	output erb_req_t req_r,
	output logic [`ERB_DW-1:0] dout,
	output logic [`ERB_DW-1:0] q
);
	erb_req_t in_r, in_nxt;
	logic [`ERB_DW-1:0] dout_r, dout_nxt, out_r, out_nxt;

	// next values; the array word is caught only on an access
	always_comb begin
		in_nxt = req;
		if (ACE && req.addr_stall) begin
			in_nxt.addr = in_r.addr; // R5
		end
		dout_nxt = (in_r.rden || in_r.wren) ? rd_word : dout_r;
		out_nxt = dout_r;
	end

	// input stage: the clear acts at once, the array only sees it next edge
	always_ff @(posedge ref_clk or negedge reset_n or posedge clr_in) begin
		if (!reset_n) begin
			in_r <= '0;
		end else if (clr_in) begin
			in_r <= '0; // R1
		end else begin
			in_r <= in_nxt;
		end
	end

	// array read latch has no user clear, so R1 leaves it alone
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			dout_r <= '0;
		end else begin
			dout_r <= dout_nxt;
		end
	end

	// output stage: cleared without waiting for an edge
	always_ff @(posedge ref_clk or negedge reset_n or posedge clr_out) begin
		if (!reset_n) begin
			out_r <= '0;
		end else if (clr_out) begin
			out_r <= '0; // R2
		end else begin
			out_r <= out_nxt;
		end
	end

	assign req_r = in_r;
	assign dout = dout_r;
	assign q = out_reg_en ? out_r : dout_r;

	sequence s_in_cleared;
		in_r == '0;
	endsequence
	sequence s_dout_held;
		dout_r == $past(dout_r);
	endsequence
	AST_R1_INCLR: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
		clr_in |-> s_in_cleared ##1 s_dout_held)
		else $error("input clear did not clear input stage or disturbed output");
	AST_R2_OUTCLR: assert property (@(posedge ref_clk) disable iff (!reset_n) // R2
		(clr_out && out_reg_en) |-> (q == '0))
		else $error("output clear not seen on q");
	AST_R5_ACE: assert property (@(posedge ref_clk) disable iff (!reset_n) // R5
		(ACE && req.addr_stall && !clr_in) |=> (in_r.addr == $past(in_r.addr)))
		else $error("address moved while address stall was high");
endmodule
`default_nettype wire

// ==== rtl/erb_ram.sv ====
// embedded ram block with apb control, two user ports and selectable size
// What this block does
// R1: input clear acts now, array next edge; output left alone
// R2: output clear shows on outputs immediately when the output stage is on
// R3: capacity 576, 4608 or 589824 bits by size
// R4: single, simple dual, true dual, shift, rom; shift and rom only on the small and mid sizes
// R5: parity, byte enable, pack, address stall, widths; the small size ignores address stall
// R6: same port new data except in shift mode, which returns old data; other port old
// R7: simple dual port allows unequal widths
// R8: true dual port only mid and large
`timescale 1ns/10ps
`default_nettype none
`include "erb_params.svh"
module erb_ram import erb_pkg::*; #(
	parameter erb_variant_t VARIANT = ERB_SMALL
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic aclr_in,
	input wire logic aclr_out,
	input wire erb_req_t port_a_req,
	input wire erb_req_t port_b_req,
	output logic [`ERB_DW-1:0] q_a,
	output logic [`ERB_DW-1:0] q_b,
	output logic cfg_err
);
	localparam int TOTAL = (VARIANT == ERB_SMALL) ? `ERB_SMALL_BITS :
		(VARIANT == ERB_MID) ? `ERB_MID_BITS : `ERB_LARGE_BITS; // R3
	localparam int MAXW = (VARIANT == ERB_SMALL) ? `ERB_SMALL_MAXW :
		(VARIANT == ERB_MID) ? `ERB_MID_MAXW : `ERB_DW;
	localparam int MINW = (VARIANT == ERB_LARGE) ? `ERB_LARGE_MINW : `ERB_MIN_W;

	typedef struct packed {
		logic [TOTAL-1:0] mem;
		logic [31:0] ctrl;
		logic coll;
		logic [15:0] ld_addr;
		logic [15:0] sh_ptr;
		logic [31:0] prdata;
	} erb_st_t;

	erb_st_t s_r, s_nxt;
	erb_req_t a_r, b_r;
	erb_mode_t m;
	logic [7:0] wa, wb;
	logic mode_ok, b_used, tdp, we_a, we_b, hit, ovl, setup, acc, map_ok;
	logic [`ERB_DW-1:0] rd_a, rd_b, dout_a;
	int ba, bb, g;

	// width legal for this size; true dual port caps the width
	function automatic logic w_ok(input logic [7:0] w, input logic tdp_m);
		w_ok = (w != 8'h0) && (int'(w) <= MAXW) && (int'(w) >= MINW) &&
			!(tdp_m && int'(w) > `ERB_TDP_MAXW);
	endfunction

	// byte lane gate; narrow ports write whole words, nine-bit lanes carry parity
	function automatic logic ben(input logic [`ERB_BW-1:0] be, input logic [7:0] w,
			input int i);
		int lane;
		lane = (int'(w) % `ERB_GRAN == 0) ? i / `ERB_GRAN : i / 8;
		ben = (int'(w) < `ERB_BE_MINW) || be[lane]; // R5
	endfunction

	// configuration decode and legality per size
	always_comb begin
		m = erb_mode_t'(s_r.ctrl[`ERB_CTRL_MODE_LSB +: 3]);
		wa = erb_width(s_r.ctrl[`ERB_CTRL_WA_LSB +: 4]);
		wb = erb_width(s_r.ctrl[`ERB_CTRL_WB_LSB +: 4]); // R7
		tdp = (m == ERB_TDP) || (m == ERB_PACK);
		b_used = (m == ERB_SDP) || tdp;
		mode_ok = (m == ERB_SP) || (m == ERB_SDP) ||
			(tdp && VARIANT != ERB_SMALL) || // R8
			((m == ERB_SHIFT || m == ERB_ROM) && VARIANT != ERB_LARGE); // R4
		cfg_err = !mode_ok || !w_ok(wa, tdp) || (b_used && !w_ok(wb, tdp));
	end

	// array access, apb loads first, then port a, then port b
	always_comb begin
		s_nxt = s_r;
		rd_a = '0;
		rd_b = '0;
		setup = psel && !penable;
		acc = psel && penable;
		g = int'(s_r.ld_addr) * `ERB_GRAN;
		case (paddr)
			`ERB_CTRL_OFS, `ERB_STAT_OFS, `ERB_LDADR_OFS, `ERB_LDDAT_OFS: map_ok = 1'b1;
			default: map_ok = 1'b0;
		endcase
		// read data is caught in setup so prdata comes from a flop
		if (setup) begin
			s_nxt.prdata = '0;
			case (paddr)
				`ERB_CTRL_OFS: s_nxt.prdata = s_r.ctrl;
				`ERB_STAT_OFS: begin
					s_nxt.prdata[`ERB_STAT_ERR_BIT] = cfg_err;
					s_nxt.prdata[`ERB_STAT_COLL_BIT] = s_r.coll;
					s_nxt.prdata[`ERB_STAT_VAR_LSB +: 2] = VARIANT;
				end
				`ERB_LDADR_OFS: s_nxt.prdata[15:0] = s_r.ld_addr;
				`ERB_LDDAT_OFS: begin
					for (int j = 0; j < `ERB_GRAN; j++) begin
						if (g + j < TOTAL) begin
							s_nxt.prdata[j] = s_r.mem[g + j];
						end
					end
				end
				default: s_nxt.prdata = '0;
			endcase
		end
		// software writes; the load window is how rom contents get in
		if (acc && pwrite) begin
			case (paddr)
				`ERB_CTRL_OFS: s_nxt.ctrl = pwdata;
				`ERB_LDADR_OFS: s_nxt.ld_addr = pwdata[15:0];
				`ERB_LDDAT_OFS: begin
					for (int j = 0; j < `ERB_GRAN; j++) begin
						if (g + j < TOTAL) begin
							s_nxt.mem[g + j] = pwdata[j];
						end
					end
				end
				default: s_nxt.prdata = s_r.prdata;
			endcase
		end
		if (acc && paddr == `ERB_LDDAT_OFS) begin
			s_nxt.ld_addr = s_r.ld_addr + 16'h1;
		end
		// port b sits in the upper half when two ports are packed
		ba = int'((m == ERB_SHIFT) ? s_r.sh_ptr : a_r.addr) * int'(wa);
		bb = int'(b_r.addr) * int'(wb) + ((m == ERB_PACK) ? TOTAL / 2 : 0); // R5
		we_a = a_r.wren && !cfg_err && (m != ERB_ROM); // R4
		we_b = b_r.wren && !cfg_err && tdp; // R8
		for (int i = 0; i < `ERB_DW; i++) begin
			if (i < int'(wa) && ba + i < TOTAL) begin
				rd_a[i] = s_r.mem[ba + i];
				if (we_a && ben(a_r.byteena, wa, i)) begin
					s_nxt.mem[ba + i] = a_r.wdata[i];
					// shift taps read the oldest word, others read new data
					rd_a[i] = (m == ERB_SHIFT) ? s_r.mem[ba + i] : a_r.wdata[i]; // R6
				end
			end
			if (b_used && i < int'(wb) && bb + i < TOTAL) begin
				rd_b[i] = s_r.mem[bb + i]; // R6
				if (we_b && ben(b_r.byteena, wb, i)) begin
					s_nxt.mem[bb + i] = b_r.wdata[i];
					rd_b[i] = b_r.wdata[i]; // R6
				end
			end
		end
		// shift length is the port a address plus one word
		if (we_a && m == ERB_SHIFT) begin
			s_nxt.sh_ptr = (s_r.sh_ptr >= a_r.addr) ? 16'h0 : s_r.sh_ptr + 16'h1; // R4
		end
		// mixed port hit: old data returned, flagged since real arrays differ
		ovl = (ba < bb + int'(wb)) && (bb < ba + int'(wa));
		hit = ovl && ((we_a && b_used && b_r.rden) || (we_b && a_r.rden)); // R6
		s_nxt.coll = hit || (s_r.coll && !(acc && pwrite && paddr == `ERB_STAT_OFS &&
			pwdata[`ERB_STAT_COLL_BIT]));
	end

	// all array, control and status state, one register; the port stages sit in erb_port
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '0;
			s_r.ctrl <= `ERB_CTRL_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	erb_port #(.ACE(VARIANT != ERB_SMALL)) u_port_a (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.clr_in(aclr_in),
		.clr_out(aclr_out),
		.out_reg_en(s_r.ctrl[`ERB_CTRL_OREGA_BIT]),
		.req(port_a_req),
		.rd_word(rd_a),
		.req_r(a_r),
		.dout(dout_a),
		.q(q_a)
	);

	erb_port #(.ACE(VARIANT != ERB_SMALL)) u_port_b (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.clr_in(aclr_in),
		.clr_out(aclr_out),
		.out_reg_en(s_r.ctrl[`ERB_CTRL_OREGB_BIT]),
		.req(port_b_req),
		.rd_word(rd_b),
		.req_r(b_r),
		.dout(),
		.q(q_b)
	);

	// zero wait state slave; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = acc && !map_ok;
	assign prdata = s_r.prdata;

	AST_R3_SHAPE: assert property (@(posedge ref_clk) disable iff (!reset_n) // R3
		!cfg_err |-> (int'(wa) <= MAXW && int'(wa) >= MINW))
		else $error("legal config with out of range width");
	AST_R4_ROM: assert property (@(posedge ref_clk) disable iff (!reset_n) // R4
		(m == ERB_ROM) |-> (!we_a && !we_b))
		else $error("port write accepted in rom mode");
	AST_R6_SAME: assert property (@(posedge ref_clk) disable iff (!reset_n) // R6
		(we_a && a_r.rden && m != ERB_SHIFT && int'(wa) < `ERB_BE_MINW && !aclr_in &&
		ba < TOTAL) |=> (dout_a[0] == $past(a_r.wdata[0])))
		else $error("same port read did not return new data");
	AST_R6_MIX: assert property (@(posedge ref_clk) disable iff (!reset_n) // R6
		hit |=> s_r.coll)
		else $error("mixed port collision not flagged");
	AST_R7_MIXW: assert property (@(posedge ref_clk) disable iff (!reset_n) // R7
		(m == ERB_SDP && w_ok(wa, 1'b0) && w_ok(wb, 1'b0)) |-> !cfg_err)
		else $error("unequal simple dual port widths refused");
	AST_R8_TDP: assert property (@(posedge ref_clk) disable iff (!reset_n) // R8
		(m == ERB_TDP && VARIANT == ERB_SMALL) |-> (cfg_err && !we_b))
		else $error("true dual port allowed on small block");
endmodule
`default_nettype wire

// ==== dv/erb_fabric.sv ====
// user logic model that drives both request ports of the ram block
`timescale 1ns/10ps
`default_nettype none
`include "erb_params.svh"
module erb_fabric import erb_pkg::*; (
	input wire logic ref_clk,
	output erb_req_t port_a_req,
	output erb_req_t port_b_req
);
	// ports start quiet with byte enables at their default high
	initial begin
		port_a_req = '0;
		port_b_req = '0;
		port_a_req.byteena = '1;
		port_b_req.byteena = '1;
	end

	// one request for one edge, then both ports released
	task automatic go(input bit b, input int a, input logic [`ERB_DW-1:0] d, input bit wr);
		erb_req_t r;
		r = '0;
		r.addr = a[15:0];
		r.wdata = d;
		r.byteena = '1;
		r.wren = wr;
		r.rden = 1'b1;
		@(posedge ref_clk);
		if (b) port_b_req <= r;
		else port_a_req <= r;
		@(posedge ref_clk);
		// released lines toggle so a stale address or data is never mistaken for a request
		port_a_req <= {~port_a_req.addr, ~port_a_req.wdata, 16'hffff, 3'h0};
		port_b_req <= {~port_b_req.addr, ~port_b_req.wdata, 16'hffff, 3'h0};
	endtask

	// port a writes while port b reads, both taken at the same edge
	task automatic pair(input int aa, input logic [`ERB_DW-1:0] d, input int ab);
		erb_req_t ra, rb;
		ra = '0;
		ra.addr = aa[15:0];
		ra.wdata = d;
		ra.byteena = '1;
		ra.wren = 1'b1;
		ra.rden = 1'b1;
		rb = ra;
		rb.addr = ab[15:0];
		rb.wren = 1'b0;
		@(posedge ref_clk);
		port_a_req <= ra;
		port_b_req <= rb;
		@(posedge ref_clk);
		port_a_req <= {~port_a_req.addr, ~port_a_req.wdata, 16'hffff, 3'h0};
		port_b_req <= {~port_b_req.addr, ~port_b_req.wdata, 16'hffff, 3'h0};
	endtask
endmodule
`default_nettype wire

// ==== dv/erb_testbench.sv ====
// self-checking bench for the small embedded ram block
`timescale 1ns/10ps
`default_nettype none
`include "erb_params.svh"
module testbench import erb_pkg::*; ();
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic aclr_in = 1'b0;
	logic aclr_out = 1'b0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cfg_err;
	erb_req_t port_a_req;
	erb_req_t port_b_req;
	logic [`ERB_DW-1:0] q_a;
	logic [`ERB_DW-1:0] q_b;
	logic [575:0] mdl = '0;
	logic [31:0] seed = 32'd3394;
	logic [31:0] rd;
	logic er;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;

	always #25 ref_clk = ~ref_clk;

	erb_ram #(.VARIANT(ERB_SMALL)) dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .aclr_in(aclr_in), .aclr_out(aclr_out),
		.port_a_req(port_a_req), .port_b_req(port_b_req), .q_a(q_a), .q_b(q_b),
		.cfg_err(cfg_err));
	erb_fabric fab_u (.ref_clk(ref_clk), .port_a_req(port_a_req), .port_b_req(port_b_req));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// model: word of width w at address a spans bits a*w up; past capacity reads 0
	function automatic logic [143:0] mrd(input int a, input int w);
		mrd = '0;
		for (int i = 0; i < w; i++) if (a * w + i < 576) mrd[i] = mdl[a * w + i];
	endfunction
	function automatic void mwr(input int a, input int w, input logic [143:0] d);
		for (int i = 0; i < w; i++) if (a * w + i < 576) mdl[a * w + i] = d[i];
	endfunction

	task automatic chk(input logic [143:0] got, input logic [143:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready is seen high
	task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// a write lands at this edge; let it settle before anyone looks
		#1;
	endtask
	// port access; q looked at lat edges after the capture edge
	task automatic op(input bit b, input int a, input int w, input logic [143:0] d,
		input bit wr, input bit ok, input int lat);
		logic [143:0] dm;
		dm = d & ((144'h1 << w) - 144'h1);
		fab_u.go(b, a, dm, wr);
		if (wr && ok) mwr(a, w, dm);
		repeat (lat) @(posedge ref_clk);
		#1;
		chk(b ? q_b : q_a, mrd(a, w));
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// hang guard, more than twenty times the expected run length
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			give_verdict();
		end
	end

	initial begin
		int a;
		int p;
		logic [143:0] d;
		logic [143:0] old;
		repeat (12) @(posedge ref_clk);
		reset_n <= 1'b1;
		apb(0, 12'h000, 32'h0);
		chk(144'(rd), 144'h660);
		apb(0, 12'h004, 32'h0);
		chk(144'(rd), 144'h0);
		apb(0, 12'h040, 32'h0);
		chk(144'(er), 144'h1);
		$display("register test done");
		// last word, one past capacity, then random words, each written then read
		for (int i = 0; i < 8; i++) begin
			a = (i == 0) ? 31 : (i == 1) ? 32 : int'(rnd() % 32);
			op(0, a, 18, {112'h0, rnd()}, 1, 1, 1);
			op(0, a, 18, 144'h0, 0, 0, 1);
		end
		$display("single port test done");
		// every mode: only true dual and pack are illegal on the small size
		for (int m = 0; m < 6; m++) begin
			apb(1, 12'h000, 32'h660 | m);
			chk(144'(cfg_err), 144'((m == 2) || (m == 5)));
			apb(0, 12'h004, 32'h0);
			chk(144'(rd[0]), 144'((m == 2) || (m == 5)));
		end
		// read-only mode: contents come in through the load window, port writes refused
		apb(1, 12'h000, 32'h664);
		apb(1, 12'h008, 32'h6);
		d = {112'h0, rnd()};
		apb(1, 12'h00c, d[31:0]);
		mwr(6, 9, d);
		op(0, 3, 18, {112'h0, rnd()}, 1, 0, 1);
		apb(1, 12'h008, 32'h6);
		apb(0, 12'h00c, 32'h0);
		chk(144'(rd), mrd(6, 9));
		apb(0, 12'h008, 32'h0);
		chk(144'(rd), 144'h7);
		// shift mode, taps two words long: each write returns the word two writes back
		apb(1, 12'h000, 32'h663);
		p = 0;
		for (int i = 0; i < 4; i++) begin
			d = {112'h0, rnd()} & 144'h3ffff;
			old = mrd(p, 18);
			mwr(p, 18, d);
			p = (p == 1) ? 0 : p + 1;
			fab_u.go(0, 1, d, 1);
			@(posedge ref_clk);
			#1;
			chk(q_a, old);
		end
		$display("mode test done");
		// simple dual port, 9 wide writes on a, 18 wide reads on b
		apb(1, 12'h000, 32'h641);
		op(0, 4, 9, {112'h0, rnd()}, 1, 1, 1);
		op(0, 5, 9, {112'h0, rnd()}, 1, 1, 1);
		op(1, 2, 18, 144'h0, 0, 0, 1);
		// other port reads the word being written: old data and a sticky flag
		apb(1, 12'h000, 32'h661);
		d = {112'h0, rnd()} & 144'h3ffff;
		old = mrd(8, 18);
		fab_u.pair(8, d, 8);
		mwr(8, 18, d);
		@(posedge ref_clk);
		#1;
		chk(q_b, old);
		chk(q_a, d);
		apb(0, 12'h004, 32'h0);
		chk(144'(rd), 144'h2);
		apb(1, 12'h004, 32'h2);
		apb(0, 12'h004, 32'h0);
		chk(144'(rd), 144'h0);
		$display("mixed width test done");
		// output stage on: clear shows without an edge
		apb(1, 12'h000, 32'h1660);
		mwr(7, 18, 144'h2a5a5);
		op(0, 7, 18, 144'h2a5a5, 1, 1, 2);
		@(posedge ref_clk);
		aclr_out <= 1'b1;
		#1;
		chk(q_a, 144'h0);
		@(posedge ref_clk);
		aclr_out <= 1'b0;
		// output stage off: input clear leaves q alone, also across the next edge
		apb(1, 12'h000, 32'h660);
		op(0, 31, 18, 144'h0, 0, 0, 1);
		// a read of word 30 sits in the input stage when the clear lands: it must never show
		fab_u.go(0, 30, 144'h0, 0);
		aclr_in <= 1'b1;
		#1;
		chk(q_a, mrd(31, 18));
		@(posedge ref_clk);
		aclr_in <= 1'b0;
		#1;
		chk(q_a, mrd(31, 18));
		$display("clear test done");
		give_verdict();
	end
endmodule
`default_nettype wire
